//--- core/acc_pkg.sv
/*
  Shared constants and types for the converter control block: register
  indices, field positions, reset values, divider and phase counts.
  Assumes a 200 MHz APB clock and an analog SAR core outside the block.
*/
package acc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONFIG = 8'haa;
  localparam logic [7:0] IDX_PIN_LO = 8'hab;
  localparam logic [7:0] IDX_PIN_HI = 8'hac;
  localparam logic [7:0] IDX_CONTROL = 8'had;
  localparam logic [7:0] IDX_RESULT_LO = 8'hae;
  localparam logic [7:0] IDX_RESULT_HI = 8'haf;
  localparam logic [7:0] IDX_REFERENCE = 8'hb0;

  // Control register fields
  localparam int POS_POWER_ON = 7;
  localparam int POS_TRIGGER = 6;
  localparam int POS_DONE_FLAG = 5;
  localparam int POS_CHAN_LSB = 0;
  // Config register fields
  localparam int POS_LONG_SAMPLE = 2;
  localparam int POS_DIV_LSB = 0;
  // Reference register field
  localparam int POS_REF_LSB = 0;

  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [2:0] RST_CONFIG = 3'h0;
  localparam logic [15:0] RST_PIN_EN = 16'h0000;
  localparam logic [1:0] RST_REFERENCE = 2'h0;

  // Channel codes of note
  localparam logic [4:0] CHAN_LAST_PIN = 5'h0f;
  localparam logic [4:0] CHAN_QUARTER_SUPPLY = 5'h1f;

  // System clock divisors minus one, per divider code 00..11
  localparam logic [3:0] DIV_LAST_00 = 4'hf;
  localparam logic [3:0] DIV_LAST_01 = 4'hb;
  localparam logic [3:0] DIV_LAST_10 = 4'h5;
  localparam logic [3:0] DIV_LAST_11 = 4'h3;

  // Converter clock counts per phase
  localparam logic [5:0] SAMPLE_SHORT = 6'd6;
  localparam logic [5:0] SAMPLE_LONG = 6'd36;
  localparam logic [5:0] CONV_CLOCKS = 6'd14;
  localparam logic [5:0] RESULT_BITS = 6'd12;
  localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;

  // Clock rates; converter clock is rated up to 1 MHz
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int CONV_CLK_MAX_HZ = 1_000_000;
  localparam int MIN_DIV_FOR_RATE = (SYS_CLK_HZ + CONV_CLK_MAX_HZ - 1)
    / CONV_CLK_MAX_HZ;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SAMPLE,
    PH_CONVERT
  } acc_phase_t;

  typedef struct packed {
    acc_phase_t phase;
    logic [3:0] div_cnt;
    logic tick;
    logic [5:0] clk_cnt;
    logic [11:0] sar;
    logic [11:0] result;
    logic power;
    logic flag;
    logic [4:0] chan;
    logic long_sample;
    logic [1:0] clk_div;
    logic [15:0] pin_en;
    logic [1:0] ref_sel;
    logic conv_clk;
    logic sample_hold;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } acc_state_t;

endpackage : acc_pkg

//--- core/acc_top.sv
/*
  Converter control block: APB register file, converter clock divider,
  sample and successive-approximation sequencing, completion flag.
  Assumes an external comparator and DAC forming the analog SAR core;
  comparator input is synchronous to pclk.
*/
// Overview of operation
// - Converter powered only while the power-on bit 7 is one.
// - Writing one to trigger bit 6 starts converting the selected input; here only with bit 7 written one in the same write and the sequencer idle.
// - Writing zero to the trigger bit does nothing.
// - Starting a conversion clears the completion flag bit 5.
// - Finishing a conversion sets the completion flag.
// - The completion flag is also the converter interrupt request.
// - Channel codes 00000 to 01110 select inputs zero to fourteen.
// - Successive approximation path, 12-bit result, 17 input channels.
// - Sixteen channels share pins, enabled per pin by software.
// - An internal channel measures one quarter of the supply.
// - Four reference sources: supply, 1.024V, 2.4V or 2.048V.
// - Converter clock is derived from the system clock.
// - Converter clock may run up to 1 MHz; here 12.5 MHz or more at every divider code.
// - Code 01111 selects input fifteen, 11111 the quarter supply.
// - Sample 6 or 36 converter clocks, then 14 conversion clocks.
// - Converter clock is system clock divided by 16, 12, 6 or 4.
// - Reference codes 00 supply, 01 1.024V, 10 2.4V, 11 2.048V.
module acc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_in,
  output logic converter_power_on,
  output logic converter_clock,
  output logic sample_hold,
  output logic [4:0] input_channel_select,
  output logic [15:0] analog_input_enable,
  output logic [1:0] reference_source_select,
  output logic [11:0] dac_code,
  output logic conversion_done_flag
);
  import acc_pkg::*;

  acc_state_t st_ff;
  acc_state_t nxt_st;
  logic [7:0] reg_idx;
  logic addr_ok;
  logic access_first;
  logic access_done;
  logic wr_done;
  logic start;
  logic [3:0] div_last;
  logic [5:0] sample_last;
  logic [31:0] rd_mux;

  // Word index from byte address; low two bits must be zero
  assign reg_idx = paddr[9:2];
  assign access_first = psel && penable && !st_ff.pready;
  assign access_done = psel && penable && st_ff.pready;
  assign wr_done = access_done && pwrite && !st_ff.pslverr;

  // Address decode of the mapped words
  always_comb
  begin
    addr_ok = 1'b0;
    if (paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0)
    begin
      case (reg_idx)
        IDX_CONFIG, IDX_PIN_LO, IDX_PIN_HI, IDX_CONTROL,
        IDX_RESULT_LO, IDX_RESULT_HI, IDX_REFERENCE: addr_ok = 1'b1;
        default: addr_ok = 1'b0;
      endcase
    end
  end

  // Read data; trigger position always reads zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (reg_idx)
      IDX_CONTROL:
      begin
        rd_mux[POS_POWER_ON] = st_ff.power;
        rd_mux[POS_TRIGGER] = 1'b0;
        rd_mux[POS_DONE_FLAG] = st_ff.flag;
        rd_mux[POS_CHAN_LSB +: 5] = st_ff.chan;
      end
      IDX_CONFIG:
      begin
        rd_mux[POS_LONG_SAMPLE] = st_ff.long_sample;
        rd_mux[POS_DIV_LSB +: 2] = st_ff.clk_div;
      end
      IDX_PIN_LO: rd_mux[7:0] = st_ff.pin_en[7:0];
      IDX_PIN_HI: rd_mux[7:0] = st_ff.pin_en[15:8];
      IDX_RESULT_LO: rd_mux[7:0] = st_ff.result[7:0];
      IDX_RESULT_HI: rd_mux[3:0] = st_ff.result[11:8];
      IDX_REFERENCE: rd_mux[POS_REF_LSB +: 2] = st_ff.ref_sel;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Divisor and sample length from the config register; even divide by 16 gives
  // 12.5 MHz from the 200 MHz clock, so no divider code keeps the 1 MHz ceiling
  always_comb
  begin
    case (st_ff.clk_div)
      2'b00: div_last = DIV_LAST_00;
      2'b01: div_last = DIV_LAST_01;
      2'b10: div_last = DIV_LAST_10;
      default: div_last = DIV_LAST_11;
    endcase
    sample_last = (st_ff.long_sample ? SAMPLE_LONG : SAMPLE_SHORT)
      - 6'd1;
  end

  // A start needs a one in the trigger bit, power and an idle sequencer;
  // a trigger while busy is dropped so a running result is never torn
  assign start = wr_done && reg_idx == IDX_CONTROL
    && pwdata[POS_TRIGGER] && pwdata[POS_POWER_ON]
    && st_ff.phase == PH_IDLE;

  // Next-state logic for the whole block
  always_comb
  begin
    nxt_st = st_ff;
    // APB: one wait state, answer registered
    if (access_first)
    begin
      nxt_st.pready = 1'b1;
      nxt_st.pslverr = !addr_ok;
      nxt_st.prdata = addr_ok && !pwrite ? rd_mux : 32'h0000_0000;
    end
    else
    begin
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata = 32'h0000_0000;
    end
    // Register writes at the completing edge; result words are read-only
    if (wr_done)
    begin
      case (reg_idx)
        IDX_CONTROL:
        begin
          nxt_st.power = pwdata[POS_POWER_ON];
          nxt_st.chan = pwdata[POS_CHAN_LSB +: 5];
          if (!pwdata[POS_DONE_FLAG])
            nxt_st.flag = 1'b0;
        end
        IDX_CONFIG:
        begin
          nxt_st.long_sample = pwdata[POS_LONG_SAMPLE];
          nxt_st.clk_div = pwdata[POS_DIV_LSB +: 2];
        end
        IDX_PIN_LO: nxt_st.pin_en[7:0] = pwdata[7:0];
        IDX_PIN_HI: nxt_st.pin_en[15:8] = pwdata[7:0];
        IDX_REFERENCE: nxt_st.ref_sel = pwdata[POS_REF_LSB +: 2];
        default: nxt_st.power = st_ff.power;
      endcase
    end
    // Converter clock divider, running only while busy
    if (st_ff.phase == PH_IDLE)
    begin
      nxt_st.div_cnt = 4'h0;
      nxt_st.tick = 1'b0;
    end
    else if (st_ff.div_cnt == div_last)
    begin
      nxt_st.div_cnt = 4'h0;
      nxt_st.tick = 1'b1;
    end
    else
    begin
      nxt_st.div_cnt = st_ff.div_cnt + 4'h1;
      nxt_st.tick = 1'b0;
    end
    // Sequencer
    case (st_ff.phase)
      PH_IDLE:
      begin
        if (start)
        begin
          nxt_st.phase = PH_SAMPLE;
          nxt_st.clk_cnt = 6'd0;
          nxt_st.flag = 1'b0;
        end
      end
      PH_SAMPLE:
      begin
        if (st_ff.tick)
        begin
          // At or past the end, so shortening the sample mid-run cannot wrap
          if (st_ff.clk_cnt >= sample_last)
          begin
            nxt_st.phase = PH_CONVERT;
            nxt_st.clk_cnt = 6'd0;
            nxt_st.sar = SAR_FIRST_TRIAL;
          end
          else
            nxt_st.clk_cnt = st_ff.clk_cnt + 6'd1;
        end
      end
      PH_CONVERT:
      begin
        if (st_ff.tick)
        begin
          // Twelve bit decisions, then two settling clocks
          if (st_ff.clk_cnt < RESULT_BITS)
          begin
            if (!comparator_in)
              nxt_st.sar[4'd11 - st_ff.clk_cnt[3:0]] = 1'b0;
            if (st_ff.clk_cnt != RESULT_BITS - 6'd1)
              nxt_st.sar[4'd10 - st_ff.clk_cnt[3:0]] = 1'b1;
          end
          nxt_st.clk_cnt = st_ff.clk_cnt + 6'd1;
          if (st_ff.clk_cnt == CONV_CLOCKS - 6'd1)
          begin
            nxt_st.phase = PH_IDLE;
            nxt_st.flag = 1'b1;
            nxt_st.result = st_ff.sar;
          end
        end
      end
      default: nxt_st.phase = PH_IDLE;
    endcase
    // High for the first half of each converter clock; follows the next
    // phase so the clock is already low in the cycle the flag rises
    nxt_st.conv_clk = nxt_st.phase != PH_IDLE
      && nxt_st.div_cnt <= (div_last >> 1);
    // Power removal aborts any conversion at once
    if (!nxt_st.power)
    begin
      nxt_st.phase = PH_IDLE;
      nxt_st.conv_clk = 1'b0;
    end
    nxt_st.sample_hold = nxt_st.phase == PH_SAMPLE;
  end

  // Single state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.phase <= PH_IDLE;
      st_ff.power <= RST_CONTROL[POS_POWER_ON];
      st_ff.flag <= RST_CONTROL[POS_DONE_FLAG];
      st_ff.chan <= RST_CONTROL[4:0];
      st_ff.long_sample <= RST_CONFIG[POS_LONG_SAMPLE];
      st_ff.clk_div <= RST_CONFIG[1:0];
      st_ff.pin_en <= RST_PIN_EN;
      st_ff.ref_sel <= RST_REFERENCE;
    end
    else
      st_ff <= nxt_st;
  end

  // Outputs straight from the state register
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign converter_power_on = st_ff.power;
  assign converter_clock = st_ff.conv_clk;
  assign sample_hold = st_ff.sample_hold;
  assign input_channel_select = st_ff.chan;
  assign analog_input_enable = st_ff.pin_en;
  assign reference_source_select = st_ff.ref_sel;
  assign dac_code = st_ff.sar;
  assign conversion_done_flag = st_ff.flag;

  // Checks on the sequencing
  a_busy_needs_power: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_ff.phase != PH_IDLE |-> st_ff.power)
    else $error("sequencer busy while unpowered");

  a_trigger_starts: assert property (
    @(posedge pclk) disable iff (!presetn)
    start |=> st_ff.phase == PH_SAMPLE && st_ff.sample_hold)
    else $error("trigger did not start sampling");

  a_zero_no_start: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_done && reg_idx == IDX_CONTROL && !pwdata[POS_TRIGGER]
    && st_ff.phase == PH_IDLE |=> st_ff.phase == PH_IDLE)
    else $error("zero trigger write started a conversion");

  a_start_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    start |=> !st_ff.flag)
    else $error("start did not clear the flag");

  a_done_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_ff.phase == PH_CONVERT && st_ff.tick && st_ff.power
    && st_ff.clk_cnt == CONV_CLOCKS - 6'd1
    |=> st_ff.flag && st_ff.phase == PH_IDLE)
    else $error("completion did not set the flag");

  a_flag_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_ff.flag && !(wr_done && reg_idx == IDX_CONTROL) |=> st_ff.flag)
    else $error("flag cleared without software");

  a_trigger_reads_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_ff.pready && !pwrite && reg_idx == IDX_CONTROL
    |-> !st_ff.prdata[POS_TRIGGER])
    else $error("trigger bit read as one");

  a_result_load: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st_ff.flag) |-> st_ff.result == $past(st_ff.sar))
    else $error("result not loaded with the flag");

  a_divider_min: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_ff.tick |=> !st_ff.tick [*3])
    else $error("converter clock faster than divide by four");

  a_idle_clock_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_ff.phase == PH_IDLE |-> !st_ff.conv_clk)
    else $error("converter clock running while idle");

  a_hold_in_sample: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_ff.sample_hold == (st_ff.phase == PH_SAMPLE))
    else $error("sample hold out of step with the phase");

  a_zero_keeps_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_done && reg_idx == IDX_CONTROL && !pwdata[POS_TRIGGER]
    && pwdata[POS_DONE_FLAG] && st_ff.phase == PH_IDLE
    |=> st_ff.flag == $past(st_ff.flag))
    else $error("zero trigger write changed the flag");

  a_first_trial: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_ff.phase == PH_SAMPLE ##1 st_ff.phase == PH_CONVERT
    |-> st_ff.sar == SAR_FIRST_TRIAL)
    else $error("conversion did not open with the middle trial");

  a_done_clock_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st_ff.flag) |-> !st_ff.conv_clk && st_ff.phase == PH_IDLE)
    else $error("converter clock still running at completion");

endmodule : acc_top

//--- sim/acc_tb.sv
/*
  Self-checking bench for the converter control block: APB register
  access, channel, pin and reference selection, timed conversions.
  Assumes the block answers APB after one wait state and that the bench
  alone plays the comparator, settling on a fixed target code.
*/
module tb;
  import acc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic comparator_in;
  logic converter_power_on;
  logic converter_clock;
  logic sample_hold;
  logic [4:0] input_channel_select;
  logic [15:0] analog_input_enable;
  logic [1:0] reference_source_select;
  logic [11:0] dac_code;
  logic conversion_done_flag;
  logic [11:0] tgt;
  int n_mismatch;
  int n_tests;

  acc_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparator_in(comparator_in),
    .converter_power_on(converter_power_on),
    .converter_clock(converter_clock), .sample_hold(sample_hold),
    .input_channel_select(input_channel_select),
    .analog_input_enable(analog_input_enable),
    .reference_source_select(reference_source_select),
    .dac_code(dac_code), .conversion_done_flag(conversion_done_flag)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Ideal comparator: trial kept whenever target is at or above it
  always @(posedge pclk)
    comparator_in <= (tgt >= dac_code);

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ba

  task automatic complete_run();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the edge settle before callers look at outputs
    #1;
    if (k >= 20)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ba(idx), {24'h0, d}, r, e);
    check({31'h0, e}, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, ba(idx), 32'h0, r, e);
    check(r, {24'h0, exp});
    check({31'h0, e}, 32'h0);
  endtask : rd

  // Start a conversion, time it, then check result and flag
  task automatic conv(input logic [1:0] dv, input logic lg,
    input logic [4:0] ch, input logic [11:0] t);
    int d;
    int s;
    int n;
    d = (dv == 2'b00) ? 16 : (dv == 2'b01) ? 12 : (dv == 2'b10) ? 6 : 4;
    s = lg ? 36 : 6;
    tgt = t;
    wr(IDX_CONFIG, {5'h0, lg, dv});
    rd(IDX_CONFIG, {5'h0, lg, dv});
    wr(IDX_CONTROL, {3'b110, ch});
    @(posedge pclk);
    #1;
    check({31'h0, conversion_done_flag}, 32'h0);
    check({31'h0, sample_hold}, 32'h1);
    check({31'h0, converter_clock}, 32'h1);
    n = 1;
    while (conversion_done_flag !== 1'b1 && n < 2 * d * (s + 14) + 50)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (conversion_done_flag !== 1'b1)
    begin
      n_mismatch++;
      complete_run();
    end
    check({31'h0, conversion_done_flag}, 32'h1);
    check({31'h0, converter_clock}, 32'h0);
    check({20'h0, dac_code}, {20'h0, t});
    // Allow one divisor below and two divisors plus four cycles above D*(S+14)
    check(32'(n >= d * (s + 14) - d && n <= d * (s + 14) + 2 * d + 4),
      32'h1);
    rd(IDX_RESULT_LO, t[7:0]);
    rd(IDX_RESULT_HI, {4'h0, t[11:8]});
    rd(IDX_CONTROL, {3'b101, ch});
    check({31'h0, conversion_done_flag}, 32'h1);
  endtask : conv

  logic [31:0] r0;
  logic e0;
  logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h0e, 5'h0f, 5'h1f};

  initial
  begin
    n_mismatch = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tgt = 12'h000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    rd(IDX_CONTROL, RST_CONTROL);
    rd(IDX_CONFIG, {5'h0, RST_CONFIG});
    rd(IDX_PIN_LO, RST_PIN_EN[7:0]);
    rd(IDX_PIN_HI, RST_PIN_EN[15:8]);
    rd(IDX_REFERENCE, {6'h0, RST_REFERENCE});
    // Unmapped word is refused with an error and zero data
    apb(1'b0, 12'h2c4, 32'h0, r0, e0);
    check({31'h0, e0}, 32'h1);
    check(r0, 32'h0);
    // Every reference code reaches its select lines
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_REFERENCE, 8'(i));
      check({30'h0, reference_source_select}, 32'(i));
    end
    wr(IDX_PIN_LO, 8'h5a);
    wr(IDX_PIN_HI, 8'hc3);
    check({16'h0, analog_input_enable}, 32'hc35a);
    // Channel codes including last pin and quarter supply
    foreach (codes[i])
    begin
      wr(IDX_CONTROL, {3'b100, codes[i]});
      check({27'h0, input_channel_select}, {27'h0, codes[i]});
      check({31'h0, converter_power_on}, 32'h1);
    end
    wr(IDX_CONTROL, 8'h00);
    check({31'h0, converter_power_on}, 32'h0);
    // Trigger with power off in the same write must not start
    wr(IDX_CONTROL, 8'h40);
    repeat (3) @(posedge pclk);
    check({31'h0, sample_hold}, 32'h0);
    conv(2'b00, 1'b0, 5'h03, 12'ha5c);
    conv(2'b01, 1'b0, 5'h0e, 12'h3c1);
    conv(2'b10, 1'b0, 5'h0f, 12'hfff);
    conv(2'b11, 1'b0, 5'h1f, 12'h001);
    conv(2'b11, 1'b1, 5'h00, 12'h800);
    // Zero trigger with flag bit written one changes nothing
    wr(IDX_CONTROL, 8'ha0);
    repeat (3) @(posedge pclk);
    check({31'h0, sample_hold}, 32'h0);
    check({31'h0, conversion_done_flag}, 32'h1);
    wr(IDX_CONTROL, 8'h80);
    #1;
    check({31'h0, conversion_done_flag}, 32'h0);
    // Power removed mid conversion aborts it, flag stays clear
    wr(IDX_CONTROL, 8'hc0);
    repeat (10) @(posedge pclk);
    wr(IDX_CONTROL, 8'h00);
    @(posedge pclk);
    #1;
    check({31'h0, sample_hold}, 32'h0);
    check({31'h0, converter_clock}, 32'h0);
    repeat (250) @(posedge pclk);
    check({31'h0, conversion_done_flag}, 32'h0);
    complete_run();
  end
endmodule : tb
